// >>> verilog/touch_report_cfg.svh
`ifndef TOUCH_REPORT_CFG_SVH
`define TOUCH_REPORT_CFG_SVH

// Request codes
`define REQ_FIRST_KEY 8'hc0
`define REQ_ALL_KEYS 8'hc1
`define REQ_STATUS 8'hc2
`define REQ_NV_CRC 8'hc3
`define REQ_RAM_CRC 8'hc4
`define REQ_ERR_KEYS 8'hc5
`define REQ_OUT_STATES 8'hc6
`define REQ_LAST_CMD 8'hc7
`define REQ_SETUPS 8'hc8
`define REQ_IDENT 8'hc9
`define REQ_VERSION 8'hca
`define REQ_SIGNAL_HI 4'h2
`define REQ_BASE_HI 4'h4
`define REQ_KSTAT_HI 4'h8

// Report field positions
`define STS_FIXED_BIT 7
`define STS_DETECT_BIT 6
`define STS_CYCLE_BIT 5
`define STS_ERROR_BIT 4
`define STS_ATTN_BIT 3
`define STS_NV_BIT 2
`define STS_RESET_BIT 1
`define STS_SHIELD_BIT 0

// Sizes and timing
`define NUM_KEYS 11
`define NUM_OUTS 7
`define SETUP_BYTES 42
`define MAX_BURST_PULSES 16'd2048
`define CLK_PERIOD_NS 20
`define ABANDON_TIME_MS 100
`define ABANDON_CYCLES ((`ABANDON_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// >>> verilog/touch_report_pkg.sv
package touch_report_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_SETUPS
    } resp_state_t;
endpackage : touch_report_pkg

// >>> verilog/touch_report_responder.sv
`timescale 1ns/100ps
`default_nettype none
`include "touch_report_cfg.svh"

// Overview of operation
// - First-key byte: bit7 any touch, bit6 multi, bit5 any error, low bits index.
// - Multi-touch flag is 1 for two or more touched keys, else 0.
// - Index is sole touched key; with several, earliest-touched while it stays touched, else lowest-numbered touched key.
// - All-keys report: byte0 bits2..0 keys10..8, byte1 keys7..0.
// - Status: bit7 one, bit6 touch, bit4 error, bit3 attention pin floating.
// - Status bit5 shows cycle overrun, cleared when cycle timing met.
// - No stored setups: status bit2 set and nonvolatile CRC reads zero.
// - Status bit1 set by reset, cleared by reading status report.
// - Status bit0 shows shield active, zero when shield disabled.
// - Nonvolatile CRC request returns one checksum byte.
// - Working-memory CRC request returns one checksum byte.
// - Error-keys report uses all-keys layout; disabled keys read zero.
// - Signal request returns 16-bit signal, high byte first.
// - Reference request returns 16-bit reference, high byte first.
// - Key status: touched, low burst, max burst, suppress, calibrating, enabled.
// - Max burst fault flagged against fixed 2048-pulse limit.
// - Output report bits 6..0 show touched waveform driven per output.
// - Output report shows target state during hold or fade.
// - Last-command report gives prior command, never its own code.
// - Setups request sends 42 bytes ascending from address 0, MSB first.
// - Identification request returns fixed part code.
// - Version request returns major high nibble, minor low nibble.
// - Host stalling 100 ms mid-report abandons exchange and resets link.
module touch_report_responder
    import touch_report_pkg::*;
#(
    parameter int NKEYS = `NUM_KEYS,
    parameter int NOUTS = `NUM_OUTS,
    parameter int NSETUP = `SETUP_BYTES,
    parameter int ABANDON_CYC = `ABANDON_CYCLES,
    parameter logic [7:0] PART_ID = 8'h3c,  // Arbitrary value
    parameter logic [3:0] VER_MAJOR = 4'h1,
    parameter logic [3:0] VER_MINOR = 4'h0
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic SCK,
    input wire logic SS_N,
    input wire logic MOSI,
    output logic MISO,
    input wire logic [NKEYS-1:0] KEY_TOUCHED,
    input wire logic [NKEYS-1:0] KEY_ERROR,
    input wire logic [NKEYS-1:0] KEY_ENABLED,
    input wire logic [NKEYS-1:0] KEY_LOW_BURST,
    input wire logic [NKEYS-1:0] KEY_SUPPRESS_ON,
    input wire logic [NKEYS-1:0] KEY_CALIBRATING,
    input wire logic [NKEYS*16-1:0] KEY_SIGNAL,
    input wire logic [NKEYS*16-1:0] KEY_BASELINE,
    input wire logic [NKEYS*16-1:0] KEY_BURST_COUNT,
    input wire logic CYCLE_OVERRUN,
    input wire logic ATTN_FLOATING,
    input wire logic NV_SETUP_VALID,
    input wire logic SHIELD_ENABLED,
    input wire logic SHIELD_ACTIVE,
    input wire logic [7:0] NV_CRC,
    input wire logic [7:0] RAM_CRC,
    input wire logic [NOUTS-1:0] OUT_TARGET_STATE,
    input wire logic [NSETUP*8-1:0] SETUP_TABLE,
    output logic [7:0] CMD_BYTE,
    output logic CMD_VALID
);

    // ==========================================================
    // Serial link, sampled on MCLK
    logic sck_q;
    logic sck_rise;
    logic sck_fall;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_shift_q;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [7:0] tx_shift_q;
    logic [31:0] idle_cnt_q;
    logic abandon;
    resp_state_t state_q;
    logic [7:0] pend_q;
    logic more_q;
    logic [5:0] setup_idx_q;
    logic [7:0] last_cmd_q;
    logic reset_flag_q;
    logic [7:0] reply0;
    logic [7:0] reply1;
    logic two_bytes;

    assign sck_rise = SCK & ~sck_q;
    assign sck_fall = ~SCK & sck_q;
    assign byte_done = sck_rise & ~SS_N & (bit_cnt_q == 3'd7);
    assign rx_byte = {rx_shift_q[6:0], MOSI};
    assign abandon = (state_q != ST_IDLE) && (idle_cnt_q >= 32'(ABANDON_CYC - 1));

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= SCK;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            bit_cnt_q <= 3'd0;
            rx_shift_q <= 8'h00;
        end else if (SS_N || abandon) begin
            bit_cnt_q <= 3'd0;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'd1;
            rx_shift_q <= rx_byte;
        end
    end

    // Stall timer; only runs while a report is owed
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            idle_cnt_q <= 32'd0;
        end else if (state_q == ST_IDLE || sck_rise || abandon) begin
            idle_cnt_q <= 32'd0;
        end else begin
            idle_cnt_q <= idle_cnt_q + 32'd1;
        end
    end

    // ==========================================================
    // Report formation
    logic [NKEYS-1:0] max_burst;
    logic [NKEYS-1:0] err_vis;
    logic [3:0] first_idx_q;
    logic [NKEYS-1:0] touched_q;
    logic [3:0] key_sel;
    logic multi;

    genvar g;
    generate
        for (g = 0; g < NKEYS; g++) begin : g_key
            assign max_burst[g] = KEY_BURST_COUNT[g*16 +: 16] >= `MAX_BURST_PULSES;
            assign err_vis[g] = KEY_ERROR[g] & KEY_ENABLED[g];
        end
    endgenerate

    assign multi = (KEY_TOUCHED & (KEY_TOUCHED - NKEYS'(1))) != '0;
    assign key_sel = rx_byte[3:0];

    // Earliest touch: kept while that key stays touched
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            first_idx_q <= 4'h0;
            touched_q <= '0;
        end else begin
            touched_q <= KEY_TOUCHED;
            if (!KEY_TOUCHED[first_idx_q] || !touched_q[first_idx_q]) begin
                for (int i = NKEYS - 1; i >= 0; i--) begin
                    if (KEY_TOUCHED[i] && touched_q[i]) begin
                        first_idx_q <= 4'(i);
                    end
                end
                for (int i = NKEYS - 1; i >= 0; i--) begin
                    if (KEY_TOUCHED[i] && !touched_q[i] && touched_q == '0) begin
                        first_idx_q <= 4'(i);
                    end
                end
            end
        end
    end

    always_comb begin
        reply0 = 8'h00;
        reply1 = 8'h00;
        two_bytes = 1'b0;
        if (rx_byte == `REQ_FIRST_KEY) begin
            reply0 = {|KEY_TOUCHED, multi, |err_vis, 1'b0,
                      (|KEY_TOUCHED) ? first_idx_q : 4'h0};
        end else if (rx_byte == `REQ_ALL_KEYS) begin
            reply0 = {5'h00, KEY_TOUCHED[10:8]};
            reply1 = KEY_TOUCHED[7:0];
            two_bytes = 1'b1;
        end else if (rx_byte == `REQ_STATUS) begin
            reply0[`STS_FIXED_BIT] = 1'b1;
            reply0[`STS_DETECT_BIT] = |KEY_TOUCHED;
            reply0[`STS_CYCLE_BIT] = CYCLE_OVERRUN;
            reply0[`STS_ERROR_BIT] = |err_vis;
            reply0[`STS_ATTN_BIT] = ATTN_FLOATING;
            reply0[`STS_NV_BIT] = ~NV_SETUP_VALID;
            reply0[`STS_RESET_BIT] = reset_flag_q;
            reply0[`STS_SHIELD_BIT] = SHIELD_ENABLED & SHIELD_ACTIVE;
        end else if (rx_byte == `REQ_NV_CRC) begin
            reply0 = NV_SETUP_VALID ? NV_CRC : 8'h00;
        end else if (rx_byte == `REQ_RAM_CRC) begin
            reply0 = RAM_CRC;
        end else if (rx_byte == `REQ_ERR_KEYS) begin
            reply0 = {5'h00, err_vis[10:8]};
            reply1 = err_vis[7:0];
            two_bytes = 1'b1;
        end else if (rx_byte == `REQ_OUT_STATES) begin
            reply0 = {1'b0, OUT_TARGET_STATE};
        end else if (rx_byte == `REQ_LAST_CMD) begin
            reply0 = last_cmd_q;
        end else if (rx_byte == `REQ_IDENT) begin
            reply0 = PART_ID;
        end else if (rx_byte == `REQ_VERSION) begin
            reply0 = {VER_MAJOR, VER_MINOR};
        end else if (rx_byte == `REQ_SETUPS) begin
            reply0 = SETUP_TABLE[7:0];
        end else if (key_sel < 4'(NKEYS)) begin
            if (rx_byte[7:4] == `REQ_SIGNAL_HI) begin
                reply0 = KEY_SIGNAL[32'(key_sel)*16+8 +: 8];
                reply1 = KEY_SIGNAL[32'(key_sel)*16 +: 8];
                two_bytes = 1'b1;
            end else if (rx_byte[7:4] == `REQ_BASE_HI) begin
                reply0 = KEY_BASELINE[32'(key_sel)*16+8 +: 8];
                reply1 = KEY_BASELINE[32'(key_sel)*16 +: 8];
                two_bytes = 1'b1;
            end else if (rx_byte[7:4] == `REQ_KSTAT_HI) begin
                reply0 = {KEY_TOUCHED[key_sel], KEY_LOW_BURST[key_sel],
                          max_burst[key_sel], 2'b00, KEY_SUPPRESS_ON[key_sel],
                          KEY_CALIBRATING[key_sel], KEY_ENABLED[key_sel]};
            end
        end
    end

    // ==========================================================
    // Exchange sequencing: a request byte loads the first reply byte
    // Limitation: a command sent in place of a filler byte is dropped
    logic is_report;
    assign is_report = (rx_byte[7:4] == `REQ_SIGNAL_HI) || (rx_byte[7:4] == `REQ_BASE_HI)
        || (rx_byte[7:4] == `REQ_KSTAT_HI) || (rx_byte >= `REQ_FIRST_KEY
        && rx_byte <= `REQ_VERSION);

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= ST_IDLE;
            pend_q <= 8'h00;
            more_q <= 1'b0;
            setup_idx_q <= 6'd0;
            tx_shift_q <= 8'h00;
        end else if (abandon || SS_N) begin
            state_q <= ST_IDLE;
            tx_shift_q <= 8'h00;
        end else if (byte_done) begin
            case (state_q)
                ST_IDLE: begin
                    tx_shift_q <= reply0;
                    pend_q <= reply1;
                    if (rx_byte == `REQ_SETUPS) begin
                        state_q <= ST_SETUPS;
                        setup_idx_q <= 6'd1;
                    end else if (is_report) begin
                        state_q <= ST_SEND;
                        more_q <= two_bytes;
                    end
                end
                ST_SEND: begin
                    if (more_q) begin
                        tx_shift_q <= pend_q;
                        more_q <= 1'b0;
                    end else begin
                        tx_shift_q <= 8'h00;
                        state_q <= ST_IDLE;
                    end
                end
                ST_SETUPS: begin
                    if (32'(setup_idx_q) < NSETUP) begin
                        tx_shift_q <= SETUP_TABLE[32'(setup_idx_q)*8 +: 8];
                        setup_idx_q <= setup_idx_q + 6'd1;
                    end else begin
                        tx_shift_q <= 8'h00;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end else if (sck_fall && bit_cnt_q != 3'd0) begin
            tx_shift_q <= {tx_shift_q[6:0], 1'b0};
        end
    end

    assign MISO = tx_shift_q[7];

    // Command record; filler bytes mid-report are not commands
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            last_cmd_q <= 8'h00;
            CMD_BYTE <= 8'h00;
            CMD_VALID <= 1'b0;
        end else begin
            CMD_VALID <= 1'b0;
            if (byte_done && state_q == ST_IDLE) begin
                last_cmd_q <= rx_byte;
                CMD_BYTE <= rx_byte;
                CMD_VALID <= ~is_report;
            end
        end
    end

    // Reset flag: set by reset, cleared when a status request is received
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            reset_flag_q <= 1'b1;
        end else if (byte_done && state_q == ST_IDLE && rx_byte == `REQ_STATUS) begin
            reset_flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    AST_STATUS_CLEARS: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_STATUS
        |=> !reset_flag_q && tx_shift_q[7])
        else $error("status read did not clear reset flag");
    AST_LAST_NOT_SELF: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_LAST_CMD
        |=> tx_shift_q == $past(last_cmd_q))
        else $error("last command report wrong");
    AST_ALL_HIGH: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_ALL_KEYS
        |=> tx_shift_q[7:3] == 5'h00 && state_q == ST_SEND)
        else $error("all-keys high byte wrong");
    AST_SETUP_FIRST: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_SETUPS
        |=> setup_idx_q == 6'd1 && tx_shift_q == SETUP_TABLE[7:0])
        else $error("setups did not start at address 0");
    AST_ABANDON: assert property (@(posedge MCLK) disable iff (!NRST)
        abandon |=> state_q == ST_IDLE && bit_cnt_q == 3'd0)
        else $error("stall did not reset link");
    AST_NV_ZERO: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_NV_CRC && !NV_SETUP_VALID
        |=> tx_shift_q == 8'h00)
        else $error("nonvolatile CRC not zero");
    AST_IDENT: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_IDENT
        |=> tx_shift_q == PART_ID)
        else $error("identification byte wrong");
    AST_VERSION: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_VERSION
        |=> tx_shift_q == {VER_MAJOR, VER_MINOR})
        else $error("version byte wrong");
    AST_FIRST_FLAGS: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_FIRST_KEY && (|KEY_TOUCHED)
        |=> tx_shift_q[7] && !tx_shift_q[4])
        else $error("first-key detect flag wrong");
    AST_MULTI_FLAG: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_FIRST_KEY
        |=> tx_shift_q[6] == ($countones($past(KEY_TOUCHED)) > 1))
        else $error("multi-touch flag wrong");
    AST_ERR_DISABLED: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_ERR_KEYS
        |=> (pend_q & ~8'($past(KEY_ENABLED))) == 8'h00)
        else $error("disabled key reported in error");
    AST_NV_FLAG: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_STATUS && !NV_SETUP_VALID
        |=> tx_shift_q[`STS_NV_BIT])
        else $error("storage error bit not set");
    AST_SHIELD_OFF: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_STATUS && !SHIELD_ENABLED
        |=> !tx_shift_q[`STS_SHIELD_BIT])
        else $error("shield bit set while disabled");
    AST_KSTAT_GAP: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte[7:4] == `REQ_KSTAT_HI
        |=> tx_shift_q[4:3] == 2'b00)
        else $error("undefined key status bits not zero");
    AST_OUT_TOP: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_IDLE && rx_byte == `REQ_OUT_STATES
        |=> !tx_shift_q[7])
        else $error("output report top bit not zero");
    AST_SETUP_END: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q == ST_SETUPS && 32'(setup_idx_q) >= NSETUP
        |=> state_q == ST_IDLE)
        else $error("setups did not end after last byte");
    AST_FILLER_NOT_CMD: assert property (@(posedge MCLK) disable iff (!NRST)
        byte_done && state_q != ST_IDLE
        |=> !CMD_VALID && last_cmd_q == $past(last_cmd_q))
        else $error("filler byte taken as command");

endmodule : touch_report_responder
`default_nettype wire

// >>> verification/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Host side of the serial link, mode 0 with SCK idle low
module spi_host_model (
    input wire logic mclk,
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_cyc

    // Nothing holds MOSI once deselected, so park it at the inverse
    task automatic select(input logic on);
        @(posedge mclk);
        ss_n <= ~on;
        if (!on) mosi <= ~mosi;
        wait_cyc(4);
    endtask : select

    // High phase of 4 MCLK and low phase of 5 keep SCK well under MCLK/4
    task automatic xfer(input logic [7:0] tx, input logic report);
        logic [7:0] rx;
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk);
            mosi <= tx[i];
            wait_cyc(4);
            sck <= 1'b1;
            rx[i] = miso;
            wait_cyc(4);
            sck <= 1'b0;
        end
        @(posedge mclk);
        rx_valid <= report;
        rx_byte <= rx;
        @(posedge mclk);
        rx_valid <= 1'b0;
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// >>> verification/touch_report_responder_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "touch_report_cfg.svh"
// ==========
// Reply bytes compared with values built from the driven inputs
module touch_report_responder_bench;
    import touch_report_pkg::*;
    typedef struct {string nm; logic [7:0] v;} note_t;
    localparam logic [7:0] ID = 8'ha5;  // Arbitrary value
    logic mclk, nrst, ovr, attn, nvv, shen, shact;
    logic [10:0] touched, err, en, lowb, supp, cal;
    logic [175:0] sig, base, burst;
    logic [7:0] nvcrc, ramcrc;
    logic [6:0] outs;
    logic [335:0] setup;
    wire logic sck, ss_n, mosi, miso, rx_valid;
    wire logic [7:0] rx_byte;
    wire logic cmd_valid;
    wire logic [7:0] cmd_byte;
    note_t notes[$];
    note_t nt;
    logic [7:0] cmds[$];
    logic [7:0] ce;
    int bad_count = 0;
    int n_tests = 0;
    int seed = int'(32'he63cbc41);
    int k;
    // ==========
    // Units
    touch_report_responder #(.ABANDON_CYC(200), .PART_ID(ID),
        .VER_MINOR(4'h7)) u_touch_report_responder (.MCLK(mclk), .NRST(nrst), .SCK(sck),
        .SS_N(ss_n), .MOSI(mosi), .MISO(miso), .KEY_TOUCHED(touched), .KEY_ERROR(err),
        .KEY_ENABLED(en), .KEY_LOW_BURST(lowb), .KEY_SUPPRESS_ON(supp),
        .KEY_CALIBRATING(cal), .KEY_SIGNAL(sig), .KEY_BASELINE(base),
        .KEY_BURST_COUNT(burst), .CYCLE_OVERRUN(ovr), .ATTN_FLOATING(attn),
        .NV_SETUP_VALID(nvv), .SHIELD_ENABLED(shen), .SHIELD_ACTIVE(shact),
        .NV_CRC(nvcrc), .RAM_CRC(ramcrc), .OUT_TARGET_STATE(outs), .SETUP_TABLE(setup),
        .CMD_BYTE(cmd_byte), .CMD_VALID(cmd_valid));
    spi_host_model u_spi_host_model (.mclk(mclk), .sck(sck), .ss_n(ss_n), .mosi(mosi),
        .miso(miso), .rx_valid(rx_valid), .rx_byte(rx_byte));
    // ==========
    // Helpers
    task automatic check8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : check8

    task automatic check_cmd(input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD cmd_byte expected %h seen %h", exp, got);
        end
    endtask : check_cmd

    task automatic tally_and_finish();
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    function automatic logic [7:0] sts(input logic rflag);
        return {1'b1, |touched, ovr, |(err & en), attn, ~nvv, rflag, shen & shact};
    endfunction : sts

    task automatic rpt(input logic [7:0] code, input string nm, input logic [15:0] v,
                       input int n);
        note_t t;
        u_spi_host_model.select(1'b1);
        u_spi_host_model.xfer(code, 1'b0);
        for (int b = n - 1; b >= 0; b--) begin
            t.nm = nm;
            t.v = v[b*8+:8];
            notes.push_back(t);
            u_spi_host_model.xfer(8'h00, 1'b1);
        end
        u_spi_host_model.select(1'b0);
    endtask : rpt

    // Burst counts kept clear of the limit itself, whose edge is not pinned down
    task automatic shake();
        logic [31:0] rw;
        @(posedge mclk);
        rw = $random(seed);
        err <= 11'($random(seed));
        en <= 11'($random(seed));
        lowb <= 11'($random(seed));
        supp <= 11'($random(seed));
        cal <= 11'($random(seed));
        ovr <= rw[0];
        attn <= rw[1];
        nvv <= rw[2];
        shen <= rw[3];
        shact <= rw[4];
        outs <= rw[11:5];
        nvcrc <= rw[19:12];
        ramcrc <= rw[27:20];
        touched <= 11'($random(seed));
        for (int i = 0; i < 11; i++) begin
            sig[i*16+:16] <= 16'($random(seed));
            base[i*16+:16] <= 16'($random(seed));
            burst[i*16+:16] <= ($random(seed) & 1) ? 16'd4000 : 16'd100;
        end
        for (int i = 0; i < 42; i++) setup[i*8+:8] <= 8'($random(seed));
        @(posedge mclk);
    endtask : shake
    // ==========
    // Stimulus and checking
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (rx_valid === 1'b1) begin
            if (notes.size() > 0) nt = notes.pop_front();
            else nt = '{"unexpected", 8'hxx};
            check8(nt.nm, nt.v, rx_byte);
        end
        if (cmd_valid === 1'b1) begin
            if (cmds.size() > 0) ce = cmds.pop_front();
            else ce = 8'hxx;
            check_cmd(ce, cmd_byte);
        end
    end

    initial begin
        repeat (90000) @(posedge mclk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0;
        {touched, err, en, lowb, supp, cal, ovr, attn, nvv, shen, shact, outs} = '0;
        {sig, base, burst, nvcrc, ramcrc, setup} = '0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rpt(`REQ_STATUS, "status", {8'h00, sts(1'b1)}, 1);
        rpt(`REQ_STATUS, "status", {8'h00, sts(1'b0)}, 1);
        for (int r = 0; r < 6; r++) begin
            shake();
            k = int'($unsigned($random(seed)) % 11);
            rpt(`REQ_ALL_KEYS, "all_keys", {5'h00, touched}, 2);
            rpt(`REQ_ERR_KEYS, "err_keys", {5'h00, err & en}, 2);
            rpt(`REQ_STATUS, "status", {8'h00, sts(1'b0)}, 1);
            rpt(`REQ_NV_CRC, "nv_crc", {8'h00, nvv ? nvcrc : 8'h00}, 1);
            rpt(`REQ_RAM_CRC, "ram_crc", {8'h00, ramcrc}, 1);
            rpt(`REQ_OUT_STATES, "outs", {9'h000, outs}, 1);
            rpt({`REQ_SIGNAL_HI, 4'(k)}, "signal", sig[k*16+:16], 2);
            rpt({`REQ_BASE_HI, 4'(k)}, "baseline", base[k*16+:16], 2);
            rpt({`REQ_KSTAT_HI, 4'(k)}, "key_cond", {8'h00, touched[k], lowb[k],
                burst[k*16+:16] > 16'd2048, 2'b00, supp[k], cal[k], en[k]}, 1);
        end
        // A reset in mid-run must raise the reset flag again
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rpt(`REQ_STATUS, "status", {8'h00, sts(1'b1)}, 1);
        touched <= 11'h000;
        repeat (3) @(posedge mclk);
        touched <= 11'h080;
        repeat (3) @(posedge mclk);
        touched <= 11'h084;
        repeat (3) @(posedge mclk);
        rpt(`REQ_FIRST_KEY, "first_key", {8'h01, 2'b11, |(err & en), 5'd7}, 1);
        touched <= 11'h000;
        repeat (3) @(posedge mclk);
        touched <= 11'h400;
        repeat (3) @(posedge mclk);
        rpt(`REQ_FIRST_KEY, "first_key", {8'h01, 2'b10, |(err & en), 5'd10}, 1);
        rpt(`REQ_IDENT, "ident", {8'h00, ID}, 1);
        rpt(`REQ_LAST_CMD, "last_cmd", {8'h00, `REQ_IDENT}, 1);
        // Major version stays at its default of 1
        rpt(`REQ_VERSION, "version", 16'h0017, 1);
        // An unknown code and the byte after it are both taken as commands
        cmds.push_back(8'hcb);
        cmds.push_back(8'h00);
        rpt(8'hcb, "unknown", 16'h0000, 1);
        rpt(`REQ_LAST_CMD, "last_cmd", 16'h0000, 1);
        rpt({`REQ_SIGNAL_HI, 4'hf}, "bad_key", 16'h0000, 1);
        u_spi_host_model.select(1'b1);
        u_spi_host_model.xfer(`REQ_SETUPS, 1'b0);
        for (int a = 0; a < 42; a++) begin
            notes.push_back('{"setups", setup[a*8+:8]});
            u_spi_host_model.xfer(8'h00, 1'b1);
        end
        u_spi_host_model.xfer(`REQ_ALL_KEYS, 1'b0);
        u_spi_host_model.wait_cyc(400);
        u_spi_host_model.xfer(`REQ_IDENT, 1'b0);
        notes.push_back('{"after_stall", ID});
        u_spi_host_model.xfer(8'h00, 1'b1);
        u_spi_host_model.select(1'b0);
        for (int w = 0; w < 20 && (notes.size() > 0 || cmds.size() > 0); w++) @(posedge mclk);
        if (notes.size() > 0 || cmds.size() > 0) bad_count++;
        tally_and_finish();
    end
endmodule : touch_report_responder_bench
`default_nettype wire
